// file: design/divp_pkg.sv
package divp_pkg;
    // avalon register map (byte addresses), one word each
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_VECTOR = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'hc;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc; // shares the status word
    // flag and mask field positions, shared layout
    localparam int BIT_EXT0 = 0;
    localparam int BIT_EXT1 = 1;
    localparam int BIT_EXT2 = 2;
    localparam int BIT_TIMER = 3;
    localparam int BIT_P0_RX = 4;
    localparam int BIT_P0_TX = 5;
    localparam int BIT_P2_RX = 6;
    localparam int BIT_P2_TX = 7;
    localparam int BIT_EXT3 = 8;
    localparam int BIT_HOST = 9;
    localparam int BIT_P1_RX = 10;
    localparam int BIT_P1_TX = 11;
    localparam int BIT_DMA4 = 12;
    localparam int BIT_DMA5 = 13;
    localparam int NUM_SRC = 14;
    localparam logic [15:0] FLAG_USED = 16'h3fff;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    // vector offsets
    localparam logic [6:0] VEC_RESET = 7'h00;
    localparam logic [6:0] VEC_NMI = 7'h04;
    localparam logic [6:0] VEC_TRAP_FIRST = 7'h08;
    localparam logic [6:0] VEC_TRAP_LAST = 7'h3c;
    localparam logic [6:0] VEC_MASKABLE_BASE = 7'h40;
    localparam logic [6:0] VEC_RSVD_FIRST = 7'h78;
    localparam logic [6:0] VEC_STEP = 7'h04;
    localparam logic [4:0] TRAP_FIRST_NUM = 5'h11;
    localparam logic [4:0] TRAP_LAST_NUM = 5'h1e;
    // fixed priorities of the non-maskable sources, plus the base for the maskable ones
    localparam logic [4:0] PRI_RESET = 5'h01;
    localparam logic [4:0] PRI_NMI = 5'h02;
    localparam logic [4:0] PRI_MASKABLE_BASE = 5'h03;
    localparam logic [4:0] PRI_NONE = 5'h00;
    // event bits in the block's own interrupt status
    localparam int EV_TAKEN = 0;
    localparam int EV_NMI = 1;
    localparam int EV_TRAP = 2;
    localparam int NUM_EV = 3;
endpackage

// file: design/divp_sel_if.sv
`timescale 1ns/1ps
// pending sources to the priority picker and its answer
interface divp_sel_if;
    logic [13:0] pending;
    logic found;
    logic [3:0] index;
    modport picker (input pending, output found, output index);
    modport user (output pending, input found, input index);
endinterface

// file: design/divp_picker.sv
`timescale 1ns/1ps
// lowest bit index wins, which is the lowest priority number
module divp_picker (
    divp_sel_if.picker sel
);
    // scan from the top so the lowest set bit is left last
    always_comb begin
        sel.found = 1'b0;
        sel.index = 4'h0;
        for (int i = divp_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (sel.pending[i]) begin
                sel.found = 1'b1;
                sel.index = 4'(i);
            end
        end
    end
endmodule // divp_picker

// file: design/divp_top.sv
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module divp_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reset_pin,
    input wire logic soft_reset_trap,
    input wire logic nmi_req,
    input wire logic soft_trap_req,
    input wire logic [4:0] soft_trap_num,
    input wire logic ext_irq_0,
    input wire logic ext_irq_1,
    input wire logic ext_irq_2,
    input wire logic ext_irq_3,
    input wire logic timer_irq,
    input wire logic port0_rx_irq,
    input wire logic port0_tx_irq,
    input wire logic port1_rx_irq,
    input wire logic port1_tx_irq,
    input wire logic port2_rx_irq,
    input wire logic port2_tx_irq,
    input wire logic host_port_irq,
    input wire logic dma_ch4_irq,
    input wire logic dma_ch5_irq,
    input wire logic core_ack,
    output logic vec_valid,
    output logic [6:0] vec_offset,
    output logic [4:0] vec_priority,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    typedef enum logic [1:0] {DIVP_IDLE, DIVP_OFFER} divp_state_e;
    typedef struct packed {
        divp_state_e state;
        logic [15:0] flags;
        logic [15:0] mask;
        logic [6:0] vec;
        logic [4:0] pri;
        logic [3:0] src;
        logic maskable;
        logic [2:0] ev_status;
        logic [2:0] ev_mask;
        logic bus_ready;
        logic [31:0] rdata;
        logic [6:0] last_vec;
    } divp_s;

    divp_s r;
    divp_s next_r;
    logic [15:0] raw_req;
    logic [15:0] pend;
    divp_sel_if sel ();

    // source to flag bit placement, one function so bit map lives once
    function automatic logic [15:0] pack_sources(logic [13:0] s);
        pack_sources = {2'b00, s};
    endfunction

    // vector of a maskable flag index: base plus one step per bit
    function automatic logic [6:0] vec_of(logic [3:0] idx);
        vec_of = divp_pkg::VEC_MASKABLE_BASE
            + 7'({3'h0, idx} << 2);
    endfunction

    // bit order follows vector order, so lower index is higher priority
    assign raw_req = pack_sources({dma_ch5_irq, dma_ch4_irq, port1_tx_irq,
        port1_rx_irq, host_port_irq, ext_irq_3, port2_tx_irq, port2_rx_irq,
        port0_tx_irq, port0_rx_irq, timer_irq, ext_irq_2, ext_irq_1,
        ext_irq_0});
    assign pend = r.flags & r.mask & divp_pkg::FLAG_USED;
    assign sel.pending = pend[13:0];

    divp_picker u_picker (
        .sel(sel)
    );

    // a read is held one cycle so its data come from a flip-flop;
    // writes finish at once
    assign avs_waitrequest = avs_read && !r.bus_ready;
    assign avs_readdata = r.rdata;
    assign vec_valid = (r.state == DIVP_OFFER);
    assign vec_offset = r.vec;
    assign vec_priority = r.pri;
    assign irq = |(r.ev_status & r.ev_mask);

    // all state steps here; hardware sets beat software clears
    always_comb begin
        logic [15:0] clr;
        logic [15:0] set;
        logic [2:0] ev;
        clr = 16'h0000;
        set = raw_req & divp_pkg::FLAG_USED;
        ev = 3'h0;
        next_r = r;
        next_r.rdata = 32'h0000_0000;
        next_r.bus_ready = 1'b0;
        // register access; writing a one to a flag clears it
        if (avs_write) begin
            case (avs_address)
                divp_pkg::ADDR_FLAGS: clr = avs_writedata[15:0];
                divp_pkg::ADDR_MASK:
                    next_r.mask = avs_writedata[15:0]
                        & divp_pkg::FLAG_USED;
                divp_pkg::ADDR_IRQ_MASK:
                    next_r.ev_mask = avs_writedata[18:16];
                default: ;
            endcase
        end
        // first read cycle loads rdata, the next one completes the read;
        // a back-to-back read gets its own load cycle
        if (avs_read && !r.bus_ready) begin
            next_r.bus_ready = 1'b1;
            case (avs_address)
                divp_pkg::ADDR_FLAGS: next_r.rdata = {16'h0, r.flags};
                divp_pkg::ADDR_MASK: next_r.rdata = {16'h0, r.mask};
                divp_pkg::ADDR_VECTOR:
                    next_r.rdata = {9'h0, r.pri, 6'h0, r.src,
                        1'b0, r.last_vec};
                divp_pkg::ADDR_IRQ_STATUS:
                    next_r.rdata = {13'h0, r.ev_mask, 13'h0, r.ev_status};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        // sequencer: reset beats nmi beats trap beats maskable
        case (r.state)
            DIVP_IDLE: begin
                if (reset_pin || soft_reset_trap) begin
                    next_r.vec = divp_pkg::VEC_RESET;
                    next_r.pri = divp_pkg::PRI_RESET;
                    next_r.maskable = 1'b0;
                    next_r.state = DIVP_OFFER;
                end else if (nmi_req) begin
                    next_r.vec = divp_pkg::VEC_NMI;
                    next_r.pri = divp_pkg::PRI_NMI;
                    next_r.maskable = 1'b0;
                    next_r.state = DIVP_OFFER;
                    ev[divp_pkg::EV_NMI] = 1'b1;
                end else if (soft_trap_req
                    && soft_trap_num >= divp_pkg::TRAP_FIRST_NUM
                    && soft_trap_num <= divp_pkg::TRAP_LAST_NUM) begin
                    // trap n sits at 4*(n-15), first trap at 08h
                    next_r.vec = divp_pkg::VEC_TRAP_FIRST
                        + 7'({soft_trap_num - divp_pkg::TRAP_FIRST_NUM,
                        2'b00});
                    next_r.pri = divp_pkg::PRI_NONE;
                    next_r.maskable = 1'b0;
                    next_r.state = DIVP_OFFER;
                    ev[divp_pkg::EV_TRAP] = 1'b1;
                end else if (sel.found) begin
                    next_r.src = sel.index;
                    next_r.vec = vec_of(sel.index);
                    next_r.pri = divp_pkg::PRI_MASKABLE_BASE
                        + 5'({1'b0, sel.index});
                    next_r.maskable = 1'b1;
                    next_r.state = DIVP_OFFER;
                end
            end
            DIVP_OFFER: begin
                // core takes the vector; maskable flag cleared on take
                if (core_ack) begin
                    if (r.maskable)
                        clr[r.src] = 1'b1;
                    next_r.last_vec = r.vec;
                    next_r.state = DIVP_IDLE;
                    ev[divp_pkg::EV_TAKEN] = 1'b1;
                end
            end
            default: next_r.state = DIVP_IDLE;
        endcase
        next_r.flags = ((r.flags & ~clr) | set) & divp_pkg::FLAG_USED;
        // status clears as the read completes, only the bits it reported;
        // an event landing meanwhile or in that cycle survives
        if (avs_read && r.bus_ready
            && avs_address == divp_pkg::ADDR_IRQ_STATUS)
            next_r.ev_status = (r.ev_status & ~r.rdata[2:0]) | ev;
        else
            next_r.ev_status = r.ev_status | ev;
    end

    // single register for the whole state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '{state: DIVP_IDLE, flags: divp_pkg::FLAGS_RESET,
                mask: divp_pkg::MASK_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // offered vector never lands in the reserved span
    a_vec_not_rsvd: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vec_valid |-> vec_offset < divp_pkg::VEC_RSVD_FIRST
    ) else $error("vector in reserved range");

    // both reset sources give offset 00h, priority 1
    a_reset_vector: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!vec_valid && reset_pin)
        |=> vec_offset == 7'h00 && vec_priority == 5'h01
    ) else $error("reset vector wrong");

    a_soft_reset_vec: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!vec_valid && soft_reset_trap)
        |=> vec_offset == 7'h00 && vec_priority == 5'h01
    ) else $error("soft reset vector wrong");

    // nmi only loses to reset
    a_nmi_vector: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!vec_valid && !reset_pin && !soft_reset_trap && nmi_req)
        |=> vec_offset == 7'h04 && vec_priority == 5'h02
    ) else $error("nmi vector wrong");

    // maskable source n: 40h plus four per step, priority n plus 3
    a_mask_step: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (vec_valid && r.maskable)
        |-> vec_offset == 7'h40 + 7'({r.src, 2'b00})
            && vec_priority == 5'(r.src) + 5'h03
    ) else $error("maskable vector off step");

    // traps carry no priority and stay inside their span
    a_trap_range: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (vec_valid && vec_priority == 5'h00)
        |-> vec_offset >= 7'h08 && vec_offset <= 7'h3c
    ) else $error("trap vector out of range");

    a_trap_first: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!vec_valid && !reset_pin && !soft_reset_trap && !nmi_req
            && soft_trap_req && soft_trap_num == 5'h11)
        |=> vec_offset == 7'h08 && vec_priority == 5'h00
    ) else $error("first trap vector wrong");

    // at the choice, no lower pending bit was passed over
    a_lowest_first: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (vec_valid && !$past(vec_valid) && r.maskable)
        |-> ($past(pend[13:0]) & ((14'h2 << r.src) - 14'h1))
            == (14'h1 << r.src)
    ) else $error("higher priority skipped");

    // an offer stands unchanged until the core takes it
    a_offer_holds: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (vec_valid && !core_ack)
        |=> vec_valid && $stable(vec_offset) && $stable(vec_priority)
    ) else $error("offer dropped before take");

    // a request sets its own flag bit at the next edge
    a_flag_set: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        dma_ch5_irq |=> r.flags[13]
    ) else $error("dma5 flag not set");

    a_port0_flag: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        port0_rx_irq && port2_tx_irq |=> r.flags[4] && r.flags[7]
    ) else $error("low flag layout wrong");

    a_timer_flag: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ext_irq_0 && timer_irq |=> r.flags[0] && r.flags[3]
    ) else $error("timer flag layout wrong");

    a_ext3_flag: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ext_irq_3 && host_port_irq |=> r.flags[8] && r.flags[9]
    ) else $error("high flag layout wrong");

    a_dma4_flag: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        dma_ch4_irq |=> r.flags[12]
    ) else $error("dma4 flag not set");

    // reserved bits never hold a one
    a_rsvd_zero: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        r.flags[15:14] == 2'b00 && r.mask[15:14] == 2'b00
    ) else $error("reserved flag bits set");

    // main scenarios: each kind of take and a raised interrupt
    c_reset_taken: cover property (@(posedge core_clk)
        vec_valid && vec_offset == 7'h00 && core_ack);
    c_nmi_taken: cover property (@(posedge core_clk)
        vec_valid && vec_offset == 7'h04 && core_ack);
    c_trap_taken: cover property (@(posedge core_clk)
        vec_valid && vec_priority == 5'h00 && core_ack);
    c_dma5_taken: cover property (@(posedge core_clk)
        vec_valid && vec_offset == 7'h74 && core_ack);
    c_irq_out: cover property (@(posedge core_clk) irq);
endmodule // divp_top

// file: dv/divp_core_model.sv
`timescale 1ns/1ps
// stand-in for the core sequencer: takes each offered vector after a wait
module divp_core_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic vec_valid,
    input wire logic [6:0] vec_offset,
    input wire logic [4:0] vec_priority,
    input wire logic [3:0] ack_wait,
    output logic core_ack
);
    logic [3:0] cnt;
    logic [11:0] seen[$];
    // ack lasts one cycle so a single offer is never taken twice
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_ack <= 1'b0;
            cnt <= 4'h0;
        end else if (core_ack) begin
            core_ack <= 1'b0;
            cnt <= 4'h0;
            if (vec_valid === 1'b1) seen.push_back({vec_priority, vec_offset});
        end else if (vec_valid === 1'b1 && cnt >= ack_wait) begin
            core_ack <= 1'b1;
        end else if (vec_valid === 1'b1) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // divp_core_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_req = 1'b0;
    logic srst_req = 1'b0;
    logic nmi_req = 1'b0;
    logic trap_req = 1'b0;
    logic [4:0] trap_num = 5'h00;
    logic [13:0] src = 14'h0000;
    logic [3:0] bus_addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ack_wait = 4'h0;
    logic core_ack, vec_valid, irq, wait_req;
    logic [6:0] vec_offset;
    logic [4:0] vec_priority;
    logic [31:0] rdata, got;
    int mismatches = 0;
    int tests_run = 0;
    // 250 MHz core clock
    always #2 core_clk = ~core_clk;
    divp_top uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reset_pin(rst_req), .soft_reset_trap(srst_req), .nmi_req(nmi_req),
        .soft_trap_req(trap_req), .soft_trap_num(trap_num),
        .ext_irq_0(src[0]), .ext_irq_1(src[1]), .ext_irq_2(src[2]),
        .timer_irq(src[3]), .port0_rx_irq(src[4]), .port0_tx_irq(src[5]),
        .port2_rx_irq(src[6]), .port2_tx_irq(src[7]), .ext_irq_3(src[8]),
        .host_port_irq(src[9]), .port1_rx_irq(src[10]),
        .port1_tx_irq(src[11]), .dma_ch4_irq(src[12]), .dma_ch5_irq(src[13]),
        .core_ack(core_ack), .vec_valid(vec_valid), .vec_offset(vec_offset),
        .vec_priority(vec_priority), .avs_address(bus_addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .irq(irq));
    divp_core_model core (.core_clk(core_clk), .sys_rst(sys_rst),
        .vec_valid(vec_valid), .vec_offset(vec_offset),
        .vec_priority(vec_priority), .ack_wait(ack_wait),
        .core_ack(core_ack));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one bus access: held until waitrequest is seen low at an edge,
    // read data taken at that edge, then one idle edge before the next
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        bus_addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        @(posedge core_clk);
        while (wait_req !== 1'b0 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        got = rdata;
        if (n >= 100) chk(32'h1, 32'h0);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic expect_vec(input logic [6:0] o, input logic [4:0] p);
        int n;
        n = 0;
        while (core.seen.size() == 0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (core.seen.size() == 0) chk(32'h1, 32'h0);
        else chk({20'h0, core.seen.pop_front()}, {20'h0, p, o});
    endtask
    // each source alone: flag bit, vector, clear at ack, slow core too
    task automatic map_test;
        for (int i = 0; i < 14; i++) begin
            ack_wait <= 4'(i);
            src <= 14'(1 << i);
            @(posedge core_clk);
            src <= 14'h0;
            @(posedge core_clk);
            bus(1'b0, 4'h0, 32'h0);
            chk(got, 32'h1 << i);
            bus(1'b1, 4'h4, 32'h1 << i);
            expect_vec(7'(8'h40 + 4 * i), 5'(3 + i));
            bus(1'b0, 4'h0, 32'h0);
            chk(got, 32'h0);
            bus(1'b1, 4'h4, 32'h0);
        end
    endtask
    // all sources at once come out in priority order
    task automatic prio_test;
        ack_wait <= 4'h1;
        bus(1'b1, 4'h4, 32'hffff);
        bus(1'b0, 4'h4, 32'h0);
        chk(got, 32'h3fff);
        src <= 14'h3fff;
        @(posedge core_clk);
        src <= 14'h0;
        for (int i = 0; i < 14; i++) expect_vec(7'(8'h40 + 4 * i), 5'(3 + i));
    endtask
    // event status: masked then unmasked, cleared by reading it
    task automatic irq_test;
        bus(1'b0, 4'hc, 32'h0);
        bus(1'b1, 4'hc, 32'h0);
        nmi_req <= 1'b1;
        @(posedge core_clk);
        nmi_req <= 1'b0;
        expect_vec(7'h04, 5'h02);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        chk(got, 32'h3);
        bus(1'b1, 4'hc, 32'h0007_0000);
        trap_num <= 5'h11;
        trap_req <= 1'b1;
        @(posedge core_clk);
        trap_req <= 1'b0;
        expect_vec(7'h08, 5'h00);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, 4'hc, 32'h0);
        chk(got, 32'h0007_0005);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(got, 32'h0);
    endtask
    // both reset sources and every trap number
    task automatic fixed_test;
        for (int n = 17; n <= 30; n++) begin
            trap_num <= 5'(n);
            trap_req <= 1'b1;
            @(posedge core_clk);
            trap_req <= 1'b0;
            expect_vec(7'(8 + 4 * (n - 17)), 5'h00);
        end
        srst_req <= 1'b1;
        @(posedge core_clk);
        srst_req <= 1'b0;
        expect_vec(7'h00, 5'h01);
        rst_req <= 1'b1;
        @(posedge core_clk);
        rst_req <= 1'b0;
        expect_vec(7'h00, 5'h01);
        bus(1'b0, 4'h8, 32'h0);
        chk(got, 32'h0004_0d00);
    endtask
    task report_and_stop;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, 4'h0, 32'h0);
        chk(got, 32'h0);
        bus(1'b0, 4'h4, 32'h0);
        chk(got, 32'h0);
        // masked flag is set, then cleared by writing a one to it
        src <= 14'h0100;
        @(posedge core_clk);
        src <= 14'h0000;
        bus(1'b0, 4'h0, 32'h0);
        chk(got, 32'h0000_0100);
        bus(1'b1, 4'h0, 32'h0000_0100);
        bus(1'b0, 4'h0, 32'h0);
        chk(got, 32'h0);
        map_test;
        prio_test;
        irq_test;
        fixed_test;
        report_and_stop;
    end
endmodule // tb
